//--- hdl/dual_zone_safety_monitor.sv
/*
 * State logic of the two zone safety control unit with APB register port.
 * Assumes sensor state, cable break and output readback arrive as digital
 * levels from the analog front end, asynchronous to mclk.
 */
// The address map and the APB interface to the registers were decided locally.
// Summary of operation
// - Automatic, idle: mains lamp only, all outputs on, alerts low.
// - Sensor one active: zone one lamp, zone one outputs off, alert high.
// - Sensor two active: zone two lamp, zone two outputs off, alert high.
// - Cable break one: flash lamps, all outputs off, both alerts high.
// - Cable break two: flash lamps, all outputs off, both alerts high.
// - Cable break one stays latched until supply is removed for 500 ms.
// - Reset modes after power-up: zone lamps lit, outputs off, alerts high.
// - Valid reset pulse: zone lamps off, outputs on, alerts low.
// - Actuated zone holds its outputs off whatever the reset input does.
// - Actuation end: automatic mode restores, reset modes wait for reset.
// - Zone one outputs disagree: monitoring fault, all off, alerts high.
// - Zone two outputs disagree: monitoring fault, all off, alerts high.
// - Zone two behaviour applies only with a second sensor connected.
// - Reset pulse 60 ms to 13 s; shorter ignored, longer is error.
// - Outputs turn on only after a fixed release delay following reset.
// - Zone two break dropped by short restart; zone two then stays off.
`timescale 1ns/1ps
`default_nettype none

module dual_zone_safety_monitor
    import safety_mon_pkg::*;
#(
    parameter int unsigned RESET_MIN = RESET_MIN_CYCLES,
    parameter int unsigned RESET_MAX = RESET_MAX_CYCLES,
    parameter int unsigned SUPPLY_OFF = SUPPLY_OFF_CYCLES,
    parameter int unsigned RELEASE = RELEASE_CYCLES,
    parameter int unsigned FLASH = FLASH_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Front end levels.
    input wire logic supply_ok_pin,
    input wire logic [1:0] sensor_active,
    input wire logic [1:0] sensor_break,
    input wire logic [3:0] safety_fb,
    input wire logic reset_input_term,
    // Outputs and lamps.
    output logic [3:0] safety_switch_out,
    output logic zone_one_alert_out,
    output logic zone_two_alert_out,
    output lamp_s lamps
);

    if (SUPPLY_OFF < 1 || RELEASE < 1 || FLASH < 1) begin : g_check
        $error("timing counts must be at least one cycle");
    end

    localparam logic [31:0] OFF_C = 32'(SUPPLY_OFF);
    localparam logic [31:0] REL_C = 32'(RELEASE);
    localparam logic [31:0] FLASH_C = 32'(FLASH);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic is_locking(input logic [1:0] mode);
        return mode != MODE_AUTO;
    endfunction : is_locking

    function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
                                     input logic [7:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // State.

    mon_state_s st_reg;
    mon_state_s st_next;

    logic rst_valid;
    logic rst_overlong;
    logic sup_ok;
    logic [1:0] act;
    logic [1:0] brk;
    logic [3:0] fb;
    logic locking;
    logic z2_en;

    assign sup_ok = st_reg.sync2[8];
    assign act = st_reg.sync2[7:6];
    assign brk = st_reg.sync2[5:4];
    assign fb = st_reg.sync2[3:0];
    assign locking = is_locking(st_reg.mode);
    assign z2_en = st_reg.z2_cfg && !st_reg.z2_dead;

    reset_pulse_qualifier #(
        .MIN_CYCLES(RESET_MIN),
        .MAX_CYCLES(RESET_MAX)
    ) u_reset_qual (
        .mclk(mclk),
        .rst(rst),
        .pin_level(reset_input_term),
        .enable(locking && st_reg.sup != SUP_OFF),
        .valid_pulse(rst_valid),
        .overlong_pulse(rst_overlong)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic fault_now;
        logic on1;
        logic on2;
        fault_now = 1'b0;
        on1 = 1'b0;
        on2 = 1'b0;
        st_next = st_reg;
        st_next.sync1 = {supply_ok_pin, sensor_active, sensor_break,
                         safety_fb};
        st_next.sync2 = st_reg.sync1;

        if (st_reg.flash_cnt >= FLASH_C - 32'h1) begin
            st_next.flash_cnt = 32'h0;
            st_next.flash = !st_reg.flash;
        end else begin
            st_next.flash_cnt = st_reg.flash_cnt + 32'h1;
        end

        case (st_reg.sup)
            SUP_OFF: begin
                if (sup_ok) begin
                    if (st_reg.off_long) begin
                        st_next.brk1 = 1'b0;
                        st_next.brk2 = 1'b0;
                        st_next.mon1 = 1'b0;
                        st_next.mon2 = 1'b0;
                        st_next.syserr = 1'b0;
                        st_next.z2_dead = 1'b0;
                    end else if (st_reg.brk2) begin
                        st_next.brk2 = 1'b0;
                        st_next.z2_dead = 1'b1;
                    end
                    st_next.lock1 = locking;
                    st_next.lock2 = locking;
                    st_next.rel_pend = 1'b0;
                    st_next.off_cnt = 32'h0;
                    st_next.off_long = 1'b0;
                    st_next.sup = SUP_RUN;
                end else if (st_reg.off_cnt >= OFF_C - 32'h1) begin
                    st_next.off_long = 1'b1;
                end else begin
                    st_next.off_cnt = st_reg.off_cnt + 32'h1;
                end
            end
            SUP_RUN, SUP_FAULT: begin
                if (!sup_ok) begin
                    st_next.sup = SUP_OFF;
                    st_next.off_cnt = 32'h0;
                    st_next.off_long = 1'b0;
                    st_next.rel_pend = 1'b0;
                end else begin
                    st_next.brk1 = st_reg.brk1 || brk[0];
                    st_next.brk2 = st_reg.brk2 || (brk[1] && z2_en);
                    st_next.mon1 = st_reg.mon1 || (fb[0] != fb[1]);
                    st_next.mon2 = st_reg.mon2
                        || (z2_en && fb[2] != fb[3]);
                    st_next.syserr = st_reg.syserr
                        || (rst_overlong && locking);
                    fault_now = st_next.brk1 || st_next.brk2
                        || st_next.mon1 || st_next.mon2 || st_next.syserr;
                    if (fault_now) begin
                        st_next.sup = SUP_FAULT;
                        st_next.rel_pend = 1'b0;
                    end

                    if (!locking) begin
                        st_next.lock1 = 1'b0;
                        st_next.lock2 = 1'b0;
                        st_next.rel_pend = 1'b0;
                    end else begin
                        if (rst_valid && !fault_now) begin
                            st_next.rel_pend = 1'b1;
                            st_next.rel_cnt = 32'h0;
                        end else if (st_reg.rel_pend) begin
                            if (st_reg.rel_cnt >= REL_C - 32'h1) begin
                                st_next.rel_pend = 1'b0;
                                st_next.lock1 = 1'b0;
                                st_next.lock2 = 1'b0;
                            end else begin
                                st_next.rel_cnt = st_reg.rel_cnt + 32'h1;
                            end
                        end
                        if (act[0]) begin
                            st_next.lock1 = 1'b1;
                        end
                        if (act[1] && z2_en) begin
                            st_next.lock2 = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_next.sup = SUP_OFF;
            end
        endcase

        // Output image, taken from the state this cycle resolves to.
        if (st_next.sup != SUP_OFF && !fault_now) begin
            on1 = !act[0] && !st_next.lock1;
            on2 = z2_en && !act[1] && !st_next.lock2;
        end
        st_next.safe = {on2, on2, on1, on1};
        if (st_next.sup == SUP_OFF) begin
            st_next.alert1 = 1'b0;
            st_next.alert2 = 1'b0;
            st_next.lamps = '0;
        end else if (fault_now) begin
            st_next.alert1 = 1'b1;
            st_next.alert2 = 1'b1;
            st_next.lamps.mains = 1'b1;
            st_next.lamps.zone_one = st_next.brk1 ? st_next.flash
                : (st_next.syserr || st_next.mon1 || st_next.mon2);
            st_next.lamps.zone_two = st_next.brk2 ? st_next.flash
                : (z2_en && (st_next.syserr || st_next.mon1
                   || st_next.mon2));
            st_next.lamps.error = (st_next.brk1 || st_next.brk2)
                ? st_next.flash : 1'b1;
        end else begin
            st_next.alert1 = !on1;
            st_next.alert2 = z2_en && !on2;
            st_next.lamps.mains = 1'b1;
            st_next.lamps.zone_one = act[0] || st_next.lock1;
            st_next.lamps.zone_two = z2_en
                && (act[1] || st_next.lock2);
            st_next.lamps.error = 1'b0;
        end

        // APB: one wait state, answer registered.
        st_next.pslverr = 1'b0;
        if (psel && penable && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0;
            if (reg_hit(paddr, CTRL_OFS)) begin
                st_next.prdata[CTRL_MODE_LSB +: 2] = st_reg.mode;
                st_next.prdata[CTRL_ZONE_TWO_BIT] = st_reg.z2_cfg;
            end else if (reg_hit(paddr, STATUS_OFS)) begin
                st_next.prdata[12:0] = {st_reg.rel_pend, st_reg.z2_dead,
                    st_reg.lock2, st_reg.lock1, st_reg.syserr, st_reg.mon2,
                    st_reg.mon1, st_reg.brk2, st_reg.brk1, act, sup_ok,
                    st_reg.sup == SUP_FAULT};
            end else if (reg_hit(paddr, OUTPUTS_OFS)) begin
                st_next.prdata[9:0] = {st_reg.lamps, st_reg.alert2,
                    st_reg.alert1, st_reg.safe};
            end else begin
                st_next.pslverr = 1'b1;
            end
        end else begin
            st_next.pready = 1'b0;
            if (psel && penable && pwrite && reg_hit(paddr, CTRL_OFS)) begin
                st_next.mode = pwdata[CTRL_MODE_LSB +: 2];
                st_next.z2_cfg = pwdata[CTRL_ZONE_TWO_BIT];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.sup <= SUP_OFF;
            st_reg.off_long <= 1'b1;
            st_reg.lock1 <= 1'b1;
            st_reg.lock2 <= 1'b1;
            st_reg.mode <= MODE_RESET;
            st_reg.z2_cfg <= ZONE_TWO_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign safety_switch_out = st_reg.safe;
    assign zone_one_alert_out = st_reg.alert1;
    assign zone_two_alert_out = st_reg.alert2;
    assign lamps = st_reg.lamps;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_actuated_zone_off: assert property (@(posedge mclk)
        disable iff (rst) (act[0] && sup_ok)
        |=> safety_switch_out[1:0] == 2'b00 && zone_one_alert_out)
        else $error("zone one on while actuated");
    a_zone_two_actuated: assert property (@(posedge mclk)
        disable iff (rst)
        (act[1] && z2_en && sup_ok && st_reg.sup != SUP_OFF)
        |=> safety_switch_out[3:2] == 2'b00 && zone_two_alert_out)
        else $error("zone two on while actuated");
    a_break_one_off: assert property (@(posedge mclk)
        disable iff (rst) (st_reg.brk1 && sup_ok && st_reg.sup != SUP_OFF)
        |=> safety_switch_out == 4'h0 && zone_one_alert_out
            && zone_two_alert_out)
        else $error("outputs on during cable break one");
    a_break_two_off: assert property (@(posedge mclk)
        disable iff (rst) (st_reg.brk2 && sup_ok && st_reg.sup != SUP_OFF)
        |=> safety_switch_out == 4'h0 && lamps.error == lamps.zone_two)
        else $error("cable break two handling wrong");
    a_break_latched: assert property (@(posedge mclk)
        disable iff (rst) (st_reg.brk1 && st_reg.sup != SUP_OFF)
        |=> st_reg.brk1)
        else $error("cable break cleared without power loss");
    a_mon_fault_off: assert property (@(posedge mclk)
        disable iff (rst)
        ((st_reg.mon1 || st_reg.mon2) && sup_ok && st_reg.sup != SUP_OFF)
        |=> safety_switch_out == 4'h0 && zone_two_alert_out)
        else $error("outputs on during monitoring fault");
    a_zone_two_ignored: assert property (@(posedge mclk)
        disable iff (rst)
        !z2_en |=> safety_switch_out[3:2] == 2'b00 && !lamps.zone_two
            || st_reg.brk2)
        else $error("inactive zone two driven");
    a_release_delay: assert property (@(posedge mclk)
        disable iff (rst)
        (locking && $fell(st_reg.lock1) && !$past(act[0]))
        |-> $past(st_reg.rel_pend))
        else $error("lock released without delay");
    a_power_up_locked: assert property (@(posedge mclk)
        disable iff (rst) (st_reg.sup == SUP_OFF && sup_ok && locking)
        |=> st_reg.lock1 ##1 safety_switch_out == 4'h0
            && (lamps.zone_one || st_reg.sup != SUP_RUN))
        else $error("reset mode not locked at power-up");
    a_auto_ready: assert property (@(posedge mclk)
        disable iff (rst)
        (!locking && st_reg.sup == SUP_RUN && sup_ok && act == 2'b00
         && brk == 2'b00 && fb[0] == fb[1] && fb[2] == fb[3] && z2_en
         && !rst_overlong)
        |=> safety_switch_out == 4'hf && !zone_one_alert_out
            && !lamps.zone_one && lamps.mains)
        else $error("automatic mode not ready");

endmodule : dual_zone_safety_monitor

`default_nettype wire

//--- hdl/reset_pulse_qualifier.sv
/*
 * Measures the width of the reset pulse on the reset input terminal.
 * Assumes the raw pin is asynchronous; it passes two flip-flops first.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_pulse_qualifier
    import safety_mon_pkg::*;
#(
    parameter int unsigned MIN_CYCLES = RESET_MIN_CYCLES,
    parameter int unsigned MAX_CYCLES = RESET_MAX_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Pulse input and qualifier enable.
    input wire logic pin_level,
    input wire logic enable,
    // Results.
    output logic valid_pulse,
    output logic overlong_pulse
);

    if (MIN_CYCLES < 2 || MAX_CYCLES <= MIN_CYCLES) begin : g_check
        $error("reset pulse limits out of range");
    end

    localparam logic [31:0] MIN_C = 32'(MIN_CYCLES);
    localparam logic [31:0] MAX_C = 32'(MAX_CYCLES);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [31:0] width;
        logic over;
        logic valid;
        logic overlong;
    } qual_s;

    qual_s q_reg;
    qual_s q_next;

    always_comb begin
        q_next = q_reg;
        q_next.sync1 = pin_level;
        q_next.sync2 = q_reg.sync1;
        q_next.prev = q_reg.sync2;
        q_next.valid = 1'b0;
        q_next.overlong = 1'b0;
        if (!enable) begin
            q_next.width = 32'h0;
            q_next.over = 1'b0;
        end else if (q_reg.sync2) begin
            if (q_reg.width < MAX_C) begin
                q_next.width = q_reg.width + 32'h1;
            end else if (!q_reg.over) begin
                q_next.over = 1'b1;
                q_next.overlong = 1'b1;
            end
        end else begin
            if (q_reg.prev && !q_reg.over && q_reg.width >= MIN_C) begin
                q_next.valid = 1'b1;
            end
            q_next.width = 32'h0;
            q_next.over = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign valid_pulse = q_reg.valid;
    assign overlong_pulse = q_reg.overlong;

    a_short_ignored: assert property (@(posedge mclk)
        disable iff (rst)
        (q_reg.prev && !q_reg.sync2 && q_reg.width < MIN_C) |=> !valid_pulse)
        else $error("short reset pulse accepted");
    a_overlong_no_valid: assert property (@(posedge mclk)
        disable iff (rst) overlong_pulse |=> !valid_pulse [*3])
        else $error("overlong pulse also accepted");

endmodule : reset_pulse_qualifier

`default_nettype wire

//--- hdl/safety_mon_pkg.sv
/*
 * Shared constants, types and state layout of the dual zone safety monitor.
 * Assumes a single 50 MHz clock and an APB register port with 32-bit data.
 */
package safety_mon_pkg;

    // Clock and timing.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RESET_MIN_MS = 60;
    localparam int unsigned RESET_MAX_MS = 13_000;
    localparam int unsigned SUPPLY_OFF_MS = 500;
    localparam int unsigned RELEASE_MS = 50;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned RESET_MIN_CYCLES = RESET_MIN_MS * CYCLES_PER_MS;
    localparam int unsigned RESET_MAX_CYCLES = RESET_MAX_MS * CYCLES_PER_MS;
    localparam int unsigned SUPPLY_OFF_CYCLES = SUPPLY_OFF_MS * CYCLES_PER_MS;
    localparam int unsigned RELEASE_CYCLES = RELEASE_MS * CYCLES_PER_MS;
    localparam int unsigned FLASH_CYCLES = FLASH_HALF_MS * CYCLES_PER_MS;

    // Register map, byte addresses.
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] OUTPUTS_OFS = 8'h08;

    // Control register fields and reset values.
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_ZONE_TWO_BIT = 2;
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_CONTROLLED = 2'h1;
    localparam logic [1:0] MODE_MANUAL = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_AUTO;
    localparam logic ZONE_TWO_RESET = 1'b1;

    // Supply and fault sequence.
    typedef enum logic [1:0] {
        SUP_OFF = 2'b00,
        SUP_RUN = 2'b01,
        SUP_FAULT = 2'b11
    } supply_e;

    typedef struct packed {
        logic mains;
        logic zone_one;
        logic zone_two;
        logic error;
    } lamp_s;

    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        supply_e sup;
        logic [31:0] off_cnt;
        logic off_long;
        logic [31:0] rel_cnt;
        logic rel_pend;
        logic [31:0] flash_cnt;
        logic flash;
        logic brk1;
        logic brk2;
        logic mon1;
        logic mon2;
        logic syserr;
        logic z2_dead;
        logic lock1;
        logic lock2;
        logic [1:0] mode;
        logic z2_cfg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] safe;
        logic alert1;
        logic alert2;
        lamp_s lamps;
    } mon_state_s;

endpackage : safety_mon_pkg

//--- verification/reset_source_model.sv
/*
 * Model of the party on the reset input: control output or push-button.
 * Assumes the bench calls pulse from its own sequence; line idles low.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
    // Clock.
    input wire logic mclk,
    // Reset input terminal drive.
    output logic term
);
    initial term = 1'b0;

    // Holds the line high for n cycles, then releases it.
    task automatic pulse(input int n);
        @(posedge mclk);
        term <= 1'b1;
        repeat (n) @(posedge mclk);
        term <= 1'b0;
    endtask : pulse
endmodule : reset_source_model

`default_nettype wire

//--- verification/test_dual_zone_safety_monitor.sv
/*
 * Self-checking bench of the dual zone safety monitor.
 * Assumes shortened counts; readback follows outputs unless flipped.
 */
`timescale 1ns/1ps
`default_nettype none

module test_dual_zone_safety_monitor
    import safety_mon_pkg::*;
;
    localparam int RMIN = 20;
    localparam int RMAX = 100;
    localparam int SOFF = 30;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, rde;
    logic supply_ok_pin, a1, a2, term, hi, lo, ph;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] sensor_active, sensor_break;
    logic [3:0] safety_fb, safe, flip;
    lamp_s lamps;
    int errors, n_tests;
    wire [9:0] outs = {safe, a1, a2, lamps};

    assign safety_fb = safe ^ flip;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    dual_zone_safety_monitor #(.RESET_MIN(RMIN), .RESET_MAX(RMAX),
        .SUPPLY_OFF(SOFF), .RELEASE(5), .FLASH(4)) i_dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok_pin(supply_ok_pin),
        .sensor_active(sensor_active), .sensor_break(sensor_break),
        .safety_fb(safety_fb), .reset_input_term(term),
        .safety_switch_out(safe), .zone_one_alert_out(a1),
        .zone_two_alert_out(a2), .lamps(lamps));

    reset_source_model i_src (.mclk(mclk), .term(term));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wait_c(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_c

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        check("apb wait", k < 50, 1);
        rd = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pins(input logic [1:0] act, brk, input logic [3:0] f);
        @(posedge mclk);
        sensor_active <= act;
        sensor_break <= brk;
        flip <= f;
        wait_c(8);
    endtask : pins

    task automatic pwr(input int n);
        @(posedge mclk);
        supply_ok_pin <= 1'b0;
        wait_c(n);
        supply_ok_pin <= 1'b1;
        wait_c(10);
    endtask : pwr

    // Error lamp must blink, in phase with the given zone lamp.
    task automatic flash(input int z);
        hi = 1'b0;
        lo = 1'b1;
        ph = 1'b1;
        repeat (20) begin
            @(posedge mclk);
            hi |= lamps.error;
            lo &= lamps.error;
            ph &= ((z ? lamps.zone_two : lamps.zone_one) === lamps.error);
        end
        check("flash", {hi, lo, ph}, 3'b101);
    endtask : flash

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    initial begin
        wait_c(30000);
        errors++;
        wrap_up();
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {supply_ok_pin, sensor_active, sensor_break, flip} = 9'h0;
        errors = 0;
        n_tests = 0;
        wait_c(2);
        rst <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl", rd, 32'h4);
        apb(1'b0, 8'h10, 32'h0);
        check("slverr", rde, 1);
        pwr(2);
        check("idle", outs, 10'b1111_00_1000);
        apb(1'b0, OUTPUTS_OFS, 32'h0);
        check("outputs reg", rd, 32'h20f);
        pins(2'b01, 2'b00, 4'h0);
        check("zone one", outs, 10'b1100_10_1100);
        pins(2'b10, 2'b00, 4'h0);
        check("zone two", outs, 10'b0011_01_1010);
        pins(2'b00, 2'b01, 4'h0);
        check("break one", outs[9:4], 6'b0000_11);
        flash(0);
        pins(2'b00, 2'b00, 4'h0);
        check("latched", outs[9:4], 6'b0000_11);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("status", rd, 32'h13);
        pwr(SOFF + 10);
        check("restart", outs, 10'b1111_00_1000);
        pins(2'b00, 2'b10, 4'h0);
        check("break two", outs[9:4], 6'b0000_11);
        flash(1);
        pwr(10);
        check("zone two dead", outs, 10'b0011_00_1000);
        pins(2'b00, 2'b00, 4'h1);
        check("mismatch one", outs[9:4], 6'b0000_11);
        pins(2'b00, 2'b00, 4'h0);
        pwr(SOFF + 10);
        pins(2'b00, 2'b00, 4'h4);
        check("mismatch two", outs[9:4], 6'b0000_11);
        pins(2'b00, 2'b00, 4'h0);
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, CTRL_OFS, 32'h4 | m);
            pwr(SOFF + 10);
            check("locked", outs, 10'b0000_11_1110);
            i_src.pulse(RMIN - 10);
            wait_c(20);
            check("short", outs, 10'b0000_11_1110);
            i_src.pulse(RMIN + 10);
            wait_c(9);
            check("delay", outs, 10'b0000_11_1110);
            wait_c(1);
            check("ready", outs, 10'b1111_00_1000);
        end
        pins(2'b01, 2'b00, 4'h0);
        i_src.pulse(RMIN + 10);
        wait_c(20);
        check("held", outs[9:6], 4'b1100);
        pins(2'b00, 2'b00, 4'h0);
        check("relock", outs[9:6], 4'b1100);
        i_src.pulse(RMAX + 10);
        wait_c(10);
        check("overlong", {outs[9:4], lamps.error}, 7'b0000_111);
        apb(1'b1, CTRL_OFS, 32'h0);
        pwr(SOFF + 10);
        pins(2'b10, 2'b00, 4'h0);
        check("no zone two", outs, 10'b0011_00_1000);
        wrap_up();
    end
endmodule : test_dual_zone_safety_monitor

`default_nettype wire
